// >>> logic/lsu_pkg.sv
package lsu_pkg;
  localparam int GPR_WIDTH       = 32;
  localparam int ADDR_WIDTH      = 32;
  localparam int LANE_BITS_32    = 2;
  localparam int LANE_BITS_64    = 3;
  localparam int NUM_COPROC      = 4;
  localparam int FUNC_WIDTH      = 25;
  localparam int REGSPEC_WIDTH   = 5;
  localparam int STYPE_WIDTH     = 5;
  localparam int HINT_WIDTH      = 5;
  localparam int CCA_WIDTH       = 3;
  localparam int SYSTEM_COPROC   = 0;
  // Unmapped window: top three address bits select it.
  localparam logic [2:0] UNMAPPED_CACHED_SEG   = 3'h4;
  localparam logic [2:0] UNMAPPED_UNCACHED_SEG = 3'h5;
  localparam logic [2:0] CCA_UNCACHED          = 3'h2;
  localparam logic [2:0] CCA_CACHED            = 3'h3;

  typedef enum logic [2:0] {
    OP_LOAD         = 3'h0,
    OP_STORE        = 3'h1,
    OP_PREFETCH     = 3'h2,
    OP_SYNC         = 3'h3,
    OP_COP_LOAD     = 3'h4,
    OP_COP_STORE    = 3'h5,
    OP_COP_FUNCTION = 3'h6
  } lsu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XLAT = 2'b01,
    ST_MEM  = 2'b11,
    ST_DONE = 2'b10
  } lsu_state_t;
endpackage : lsu_pkg

// >>> logic/mem_access_if.sv
`timescale 1ns/100ps
interface mem_access_if
  import lsu_pkg::*;
#(
  parameter int DW = 32
);
  logic                     req_valid;
  logic                     req_write;
  logic                     req_cached;
  logic                     req_prefetch;
  logic                     req_sync;
  logic [STYPE_WIDTH-1:0]   req_stype;
  logic [ADDR_WIDTH-1:0]    req_addr;
  logic [DW/8-1:0]          req_lanes;
  logic [DW-1:0]            req_wdata;
  logic                     rsp_valid;
  logic [DW-1:0]            rsp_rdata;
  logic [DW/8-1:0]          rsp_lanes_valid;
  logic                     cop_valid;
  logic [1:0]               cop_unit;
  logic [1:0]               cop_kind;
  logic [REGSPEC_WIDTH-1:0] cop_reg;
  logic [FUNC_WIDTH-1:0]    cop_func;
  logic [63:0]              cop_wdata;
  logic                     cop_rvalid;
  logic [63:0]              cop_rdata;

  modport device (
    output req_valid, req_write, req_cached, req_prefetch, req_sync, req_stype,
           req_addr, req_lanes, req_wdata, cop_valid, cop_unit, cop_kind, cop_reg,
           cop_func, cop_wdata,
    input  rsp_valid, rsp_rdata, rsp_lanes_valid, cop_rvalid, cop_rdata
  );
  modport partner (
    input  req_valid, req_write, req_cached, req_prefetch, req_sync, req_stype,
           req_addr, req_lanes, req_wdata, cop_valid, cop_unit, cop_kind, cop_reg,
           cop_func, cop_wdata,
    output rsp_valid, rsp_rdata, rsp_lanes_valid, cop_rvalid, cop_rdata
  );
endinterface : mem_access_if

// >>> logic/mem_partner.sv
`timescale 1ns/100ps
module mem_partner
  import lsu_pkg::*;
#(
  parameter int DW    = 32,
  parameter int DEPTH = 64
) (
  input  wire logic          CORE_CLK_IN,
  input  wire logic          RESET_IN,
  mem_access_if.partner      bus,
  output logic [DW-1:0]      LAST_COP_WORD_OUT,
  output logic               COP_FUNC_SEEN_OUT
);
  localparam int LB = $clog2(DW/8);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DW != 32 && DW != 64) $error("DW must be 32 or 64");
  end

  logic [DW-1:0]  mem_r [DEPTH];
  logic [63:0]    creg_r [NUM_COPROC][32];
  logic [AW-1:0]  idx;
  logic           rsp_valid_r, rsp_valid_nxt;
  logic [DW-1:0]  rdata_r, rdata_nxt;
  logic [DW/8-1:0] lv_r, lv_nxt;
  logic           crv_r, crv_nxt;
  logic [63:0]    crd_r, crd_nxt;
  logic [DW-1:0]  lcw_r, lcw_nxt;
  logic           cfs_r, cfs_nxt;

  assign idx = bus.req_addr[LB +: AW];

  always_comb begin
    rsp_valid_nxt = bus.req_valid && !bus.req_write && !bus.req_prefetch && !bus.req_sync;
    rdata_nxt     = mem_r[idx];
    lv_nxt        = bus.req_cached ? '1 : bus.req_lanes;
    crv_nxt       = bus.cop_valid && bus.cop_kind[0];
    crd_nxt       = creg_r[bus.cop_unit][bus.cop_reg];
    lcw_nxt       = lcw_r;
    cfs_nxt       = bus.cop_valid && bus.cop_kind == 2'h2;
    if (bus.cop_valid && bus.cop_kind == 2'h0) begin
      lcw_nxt = bus.cop_wdata[DW-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (bus.req_valid && bus.req_write) begin
      for (int b = 0; b < DW/8; b++) begin
        if (bus.req_lanes[b]) begin
          mem_r[idx][b*8 +: 8] <= bus.req_wdata[b*8 +: 8];
        end
      end
    end
    if (bus.cop_valid && bus.cop_kind == 2'h0) begin
      creg_r[bus.cop_unit][bus.cop_reg] <= bus.cop_wdata;
    end
    if (RESET_IN) begin
      rsp_valid_r <= 1'b0;
      rdata_r     <= '0;
      lv_r        <= '0;
      crv_r       <= 1'b0;
      crd_r       <= '0;
      lcw_r       <= '0;
      cfs_r       <= 1'b0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rdata_r     <= rdata_nxt;
      lv_r        <= lv_nxt;
      crv_r       <= crv_nxt;
      crd_r       <= crd_nxt;
      lcw_r       <= lcw_nxt;
      cfs_r       <= cfs_nxt;
    end
  end

  assign bus.rsp_valid       = rsp_valid_r;
  assign bus.rsp_rdata       = rdata_r;
  assign bus.rsp_lanes_valid = lv_r;
  assign bus.cop_rvalid      = crv_r;
  assign bus.cop_rdata       = crd_r;
  assign LAST_COP_WORD_OUT   = lcw_r;
  assign COP_FUNC_SEEN_OUT   = cfs_r;
endmodule : mem_partner

// >>> logic/load_store_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - Object address is its lowest byte.
// - Big-endian address picks MSB, little picks LSB.
// - Lanes from length and low address bits.
// - Unmapped regions translate directly, attribute included.
// - Mapped regions use table; miss faults, except prefetch, which ends silently.
// - Translation sees address, fetch/data, load/store.
// - Load returns aligned register-width element.
// - Uncached load fetches only referenced bytes.
// - Cached miss fills at least whole element.
// - Store changes only selected bytes.
// - Unwritten store lanes carry don't-care data.
// - Prefetch changes no architectural state.
// - Sync orders selected accesses for all.
// - Coprocessor receives loaded 32-bit word.
// - Coprocessor receives loaded 64-bit doubleword; with DW=32 it gets one loaded 32-bit word, upper half zero.
// - Coprocessor supplies 32-bit word for store.
// - Coprocessor supplies 64-bit doubleword for store; with DW=32 only its low 32 bits are written to memory.
// - Forward function field to named coprocessor.
// - No memory transfers for system coprocessor.
module load_store_unit
  import lsu_pkg::*;
#(
  parameter int DW = 32
) (
  input  wire logic                     CORE_CLK_IN,
  input  wire logic                     RESET_IN,
  input  wire logic                     REQ_VALID_IN,
  input  wire lsu_op_t                  REQ_OP_IN,
  input  wire logic [ADDR_WIDTH-1:0]    VIRTUAL_ADDRESS_IN,
  input  wire logic                     FETCH_OR_DATA_SELECT_IN,
  input  wire logic [3:0]               ACCESS_LENGTH_BYTES_IN,
  input  wire logic                     BIG_ENDIAN_IN,
  input  wire logic [DW-1:0]            STORE_DATA_IN,
  input  wire logic [1:0]               COPROC_UNIT_IN,
  input  wire logic                     COPROC_DOUBLE_IN,
  input  wire logic [REGSPEC_WIDTH-1:0] COPROC_REGISTER_SPECIFIER_IN,
  input  wire logic [FUNC_WIDTH-1:0]    COPROC_FUNCTION_IN,
  input  wire logic [STYPE_WIDTH-1:0]   SYNC_TYPE_IN,
  input  wire logic                     TLB_HIT_IN,
  input  wire logic                     TLB_ALLOWED_IN,
  input  wire logic [ADDR_WIDTH-1:0]    TLB_PHYS_IN,
  input  wire logic [CCA_WIDTH-1:0]     TLB_CCA_IN,
  mem_access_if.device                  bus,
  output logic                          READY_OUT,
  output logic                          DONE_OUT,
  output logic                          EXCEPTION_OUT,
  output logic [DW-1:0]                 LOAD_DATA_OUT,
  output logic [DW/8-1:0]               LOAD_LANES_OUT,
  output logic [CCA_WIDTH-1:0]          CACHEABILITY_ATTRIBUTE_OUT,
  output logic [ADDR_WIDTH-1:0]         TLB_VIRTUAL_ADDRESS_OUT,
  output logic                          TLB_FETCH_OR_DATA_SELECT_OUT,
  output logic                          TLB_LOAD_OR_STORE_SELECT_OUT
);
  localparam int LB = $clog2(DW/8);
  initial begin
    if (DW != 32 && DW != 64) $error("DW must be 32 or 64");
  end

  lsu_state_t                st_r, st_nxt;
  lsu_op_t                   op_r, op_nxt;
  logic [ADDR_WIDTH-1:0]     va_r, va_nxt;
  logic [3:0]                len_r, len_nxt;
  logic                      be_r, be_nxt, fetch_or_data_select_r, fetch_or_data_select_nxt;
  logic [DW-1:0]             sd_r, sd_nxt;
  logic [1:0]                cu_r, cu_nxt;
  logic                      ls_r, ls_nxt;
  logic [REGSPEC_WIDTH-1:0]  crs_r, crs_nxt;
  logic [FUNC_WIDTH-1:0]     cf_r, cf_nxt;
  logic [STYPE_WIDTH-1:0]    sty_r, sty_nxt;
  logic [ADDR_WIDTH-1:0]     pa_r, pa_nxt;
  logic [CCA_WIDTH-1:0]      cca_r, cca_nxt;
  logic                      rdy_r, rdy_nxt, done_r, done_nxt, exc_r, exc_nxt;
  logic [DW-1:0]             ld_r, ld_nxt;
  logic [DW/8-1:0]           ll_r, ll_nxt;
  logic [DW/8-1:0]           lanes;
  logic [LB-1:0]             lo;
  logic                      is_store;
  logic                      rv_r, rv_nxt, rw_r, rw_nxt, rc_r, rc_nxt, rp_r, rp_nxt, rs_r, rs_nxt;
  logic [DW/8-1:0]           rl_r, rl_nxt;
  logic [DW-1:0]             rwd_r, rwd_nxt;
  logic                      cv_r, cv_nxt;
  logic [1:0]                ck_r, ck_nxt;
  logic [63:0]               cwd_r, cwd_nxt;

  // Object address is the lowest byte; in big-endian the lanes mirror within the element.
  always_comb begin
    lo    = va_r[LB-1:0];
    lanes = '0;
    for (int b = 0; b < DW/8; b++) begin
      if (b >= lo && b < lo + len_r) begin
        if (be_r) begin
          lanes[DW/8-1-b] = 1'b1;
        end else begin
          lanes[b] = 1'b1;
        end
      end
    end
  end

  assign is_store = (op_r == OP_STORE) || (op_r == OP_COP_STORE);

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r; va_nxt = va_r; len_nxt = len_r; be_nxt = be_r; fetch_or_data_select_nxt = fetch_or_data_select_r;
    sd_nxt = sd_r; cu_nxt = cu_r; ls_nxt = ls_r; crs_nxt = crs_r; cf_nxt = cf_r;
    sty_nxt = sty_r; pa_nxt = pa_r; cca_nxt = cca_r;
    rdy_nxt = 1'b0; done_nxt = 1'b0; exc_nxt = 1'b0;
    ld_nxt = ld_r; ll_nxt = ll_r;
    rv_nxt = 1'b0; rw_nxt = 1'b0; rc_nxt = rc_r; rp_nxt = 1'b0; rs_nxt = 1'b0;
    rl_nxt = rl_r; rwd_nxt = rwd_r;
    cv_nxt = 1'b0; ck_nxt = ck_r; cwd_nxt = cwd_r;
    case (st_r)
      ST_IDLE: begin
        rdy_nxt = 1'b1;
        if (REQ_VALID_IN) begin
          rdy_nxt = 1'b0;
          op_nxt = REQ_OP_IN; va_nxt = VIRTUAL_ADDRESS_IN; fetch_or_data_select_nxt = FETCH_OR_DATA_SELECT_IN;
          len_nxt = ACCESS_LENGTH_BYTES_IN; be_nxt = BIG_ENDIAN_IN; sd_nxt = STORE_DATA_IN;
          cu_nxt = COPROC_UNIT_IN; crs_nxt = COPROC_REGISTER_SPECIFIER_IN;
          ls_nxt = (REQ_OP_IN == OP_STORE) || (REQ_OP_IN == OP_COP_STORE);
          cf_nxt = COPROC_FUNCTION_IN; sty_nxt = SYNC_TYPE_IN;
          if (REQ_OP_IN == OP_COP_LOAD || REQ_OP_IN == OP_COP_STORE) begin
            len_nxt = COPROC_DOUBLE_IN ? 4'h8 : 4'h4;
          end
          st_nxt = ST_XLAT;
        end
      end
      ST_XLAT: begin
        // Translation uses address, fetch/data and load/store select.
        if (op_r == OP_SYNC) begin
          rv_nxt = 1'b1; rs_nxt = 1'b1; st_nxt = ST_DONE;
        end else if (op_r == OP_COP_FUNCTION) begin
          cv_nxt = 1'b1; ck_nxt = 2'h2; st_nxt = ST_DONE;
        end else if ((op_r == OP_COP_LOAD || op_r == OP_COP_STORE) && cu_r == 2'(SYSTEM_COPROC)) begin
          exc_nxt = 1'b1; st_nxt = ST_DONE;
        end else if (va_r[31:29] == UNMAPPED_CACHED_SEG || va_r[31:29] == UNMAPPED_UNCACHED_SEG) begin
          pa_nxt  = {3'h0, va_r[28:0]};
          cca_nxt = (va_r[31:29] == UNMAPPED_CACHED_SEG) ? CCA_CACHED : CCA_UNCACHED;
          st_nxt  = ST_MEM;
        end else if (TLB_HIT_IN && TLB_ALLOWED_IN) begin
          pa_nxt = TLB_PHYS_IN; cca_nxt = TLB_CCA_IN; st_nxt = ST_MEM;
        end else begin
          // Faulting access never reaches memory or a coprocessor.
          exc_nxt = (op_r != OP_PREFETCH); st_nxt = ST_DONE;
        end
      end
      ST_MEM: begin
        rc_nxt = (cca_r != CCA_UNCACHED);
        if (op_r == OP_COP_STORE && !bus.cop_rvalid && !cv_r) begin
          cv_nxt = 1'b1; ck_nxt = 2'h1;
        end else if (op_r == OP_COP_STORE && !bus.cop_rvalid) begin
          st_nxt = ST_MEM;
        end else if (!rv_r && !bus.rsp_valid) begin
          rv_nxt = 1'b1;
          rw_nxt = is_store;
          rp_nxt = (op_r == OP_PREFETCH);
          rl_nxt = lanes;
          rwd_nxt = (op_r == OP_COP_STORE) ? bus.cop_rdata[DW-1:0] : sd_r;
          if (is_store || op_r == OP_PREFETCH) begin
            st_nxt = ST_DONE;
          end
        end else if (bus.rsp_valid) begin
          // Only requested lanes are reported; cached fills return the whole element.
          ld_nxt = bus.rsp_rdata;
          ll_nxt = bus.rsp_lanes_valid & lanes;
          if (op_r == OP_COP_LOAD) begin
            cv_nxt = 1'b1; ck_nxt = 2'h0; cwd_nxt = 64'(bus.rsp_rdata);
          end
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        done_nxt = 1'b1; rdy_nxt = 1'b1; st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      st_r <= ST_IDLE; op_r <= OP_LOAD; va_r <= '0; len_r <= '0; be_r <= 1'b0; fetch_or_data_select_r <= 1'b0;
      sd_r <= '0; cu_r <= '0; ls_r <= 1'b0; crs_r <= '0; cf_r <= '0; sty_r <= '0;
      pa_r <= '0; cca_r <= '0; rdy_r <= 1'b0; done_r <= 1'b0; exc_r <= 1'b0;
      ld_r <= '0; ll_r <= '0; rv_r <= 1'b0; rw_r <= 1'b0; rc_r <= 1'b0; rp_r <= 1'b0;
      rs_r <= 1'b0; rl_r <= '0; rwd_r <= '0; cv_r <= 1'b0; ck_r <= '0; cwd_r <= '0;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; va_r <= va_nxt; len_r <= len_nxt; be_r <= be_nxt;
      fetch_or_data_select_r <= fetch_or_data_select_nxt; sd_r <= sd_nxt; cu_r <= cu_nxt; ls_r <= ls_nxt; crs_r <= crs_nxt;
      cf_r <= cf_nxt; sty_r <= sty_nxt; pa_r <= pa_nxt; cca_r <= cca_nxt;
      rdy_r <= rdy_nxt; done_r <= done_nxt; exc_r <= exc_nxt; ld_r <= ld_nxt; ll_r <= ll_nxt;
      rv_r <= rv_nxt; rw_r <= rw_nxt; rc_r <= rc_nxt; rp_r <= rp_nxt; rs_r <= rs_nxt;
      rl_r <= rl_nxt; rwd_r <= rwd_nxt; cv_r <= cv_nxt; ck_r <= ck_nxt; cwd_r <= cwd_nxt;
    end
  end

  assign bus.req_valid    = rv_r;
  assign bus.req_write    = rw_r;
  assign bus.req_cached   = rc_r;
  assign bus.req_prefetch = rp_r;
  assign bus.req_sync     = rs_r;
  assign bus.req_stype    = sty_r;
  assign bus.req_addr     = {pa_r[ADDR_WIDTH-1:LB], {LB{1'b0}}};
  assign bus.req_lanes    = rl_r;
  assign bus.req_wdata    = rwd_r;
  assign bus.cop_valid    = cv_r;
  assign bus.cop_unit     = cu_r;
  assign bus.cop_kind     = ck_r;
  assign bus.cop_reg      = crs_r;
  assign bus.cop_func     = cf_r;
  assign bus.cop_wdata    = cwd_r;
  assign READY_OUT                  = rdy_r;
  assign DONE_OUT                   = done_r;
  assign EXCEPTION_OUT              = exc_r;
  assign LOAD_DATA_OUT              = ld_r;
  assign LOAD_LANES_OUT             = ll_r;
  assign CACHEABILITY_ATTRIBUTE_OUT = cca_r;
  // The lookup inputs stand from the cycle after acceptance, so an outside table can answer in the translate cycle.
  assign TLB_VIRTUAL_ADDRESS_OUT      = va_r;
  assign TLB_FETCH_OR_DATA_SELECT_OUT = fetch_or_data_select_r;
  assign TLB_LOAD_OR_STORE_SELECT_OUT = ls_r;
endmodule : load_store_unit

// >>> test/load_store_memory_access_monitor.sv
`timescale 1ns/100ps
module load_store_memory_access_monitor
  import lsu_pkg::*;
#(
  parameter int DW = 32
) (
  input wire logic                  CORE_CLK_IN,
  input wire logic                  RESET_IN,
  input wire logic                  req_valid,
  input wire logic                  req_write,
  input wire logic                  req_cached,
  input wire logic                  req_prefetch,
  input wire logic                  req_sync,
  input wire logic [ADDR_WIDTH-1:0] req_addr,
  input wire logic [DW/8-1:0]       req_lanes,
  input wire logic                  rsp_valid,
  input wire logic [DW/8-1:0]       rsp_lanes_valid,
  input wire logic                  cop_valid,
  input wire logic [1:0]            cop_unit,
  input wire logic [1:0]            cop_kind,
  input wire logic                  cop_rvalid
);
  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  a_addr_aligned: assert property (req_valid |-> req_addr[$clog2(DW/8)-1:0] == '0)
    else $error("request address not element aligned");
  // A gap inside the lane mask would mean the length and offset were combined wrongly.
  a_lanes_contig: assert property (req_valid |-> (req_lanes & (req_lanes + (req_lanes & -req_lanes))) == 0)
    else $error("request lanes not contiguous");
  a_lanes_used: assert property (req_valid && !req_prefetch && !req_sync |-> req_lanes != 0)
    else $error("data request with no lanes");
  a_uncached_fill: assert property (req_valid && !req_write && !req_cached && !req_prefetch && !req_sync |=>
    rsp_valid && rsp_lanes_valid == $past(req_lanes))
    else $error("uncached load lanes differ from request");
  a_cached_fill: assert property (req_valid && !req_write && req_cached && !req_prefetch && !req_sync |=>
    rsp_valid && rsp_lanes_valid == '1)
    else $error("cached fill smaller than element");
  a_prefetch_read: assert property (req_valid && req_prefetch |-> !req_write)
    else $error("prefetch issued a write");
  a_no_sys_xfer: assert property (cop_valid && cop_kind != 2'h2 |-> cop_unit != SYSTEM_COPROC)
    else $error("transfer sent to system coprocessor");
  a_cop_answer: assert property (cop_valid && cop_kind == 2'h1 |=> cop_rvalid)
    else $error("coprocessor store data not supplied");
endmodule : load_store_memory_access_monitor

// >>> test/load_store_memory_access_bench.sv
`timescale 1ns/100ps
module load_store_memory_access_bench
  import lsu_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rv = 1'b0;
  lsu_op_t     opc = OP_LOAD;
  logic [31:0] va = 32'h0, sd = 32'h0, tp = 32'h0;
  logic [3:0]  len = 4'h4, n;
  logic [1:0]  cu = 2'h1, o;
  logic        be = 1'b0, th = 1'b0, ta = 1'b0, exc, fs, fd = 1'b0, cdbl = 1'b0, tfd, tls;
  logic [4:0]  st = 5'h0, sst, crs = 5'h3;
  logic [24:0] cf = 25'h0, sfn;
  logic [2:0]  tc = 3'h0, cca;
  logic [31:0] ld, lw, cw, tva;
  logic [3:0]  ll;
  logic [1:0]  sfu;
  logic        rdy, done, exo;
  int          mismatches = 0, checks = 0, cyc = 0, nreq = 0, i, k0;

  mem_access_if #(.DW(32)) link ();
  load_store_unit #(.DW(32)) u_load_store_unit (.CORE_CLK_IN(clk), .RESET_IN(rst), .REQ_VALID_IN(rv),
    .REQ_OP_IN(opc), .VIRTUAL_ADDRESS_IN(va), .FETCH_OR_DATA_SELECT_IN(fd), .ACCESS_LENGTH_BYTES_IN(len),
    .BIG_ENDIAN_IN(be), .STORE_DATA_IN(sd), .COPROC_UNIT_IN(cu), .COPROC_DOUBLE_IN(cdbl),
    .COPROC_REGISTER_SPECIFIER_IN(crs), .COPROC_FUNCTION_IN(cf), .SYNC_TYPE_IN(st), .TLB_HIT_IN(th),
    .TLB_ALLOWED_IN(ta), .TLB_PHYS_IN(tp), .TLB_CCA_IN(tc), .bus(link), .READY_OUT(rdy), .DONE_OUT(done),
    .EXCEPTION_OUT(exo), .LOAD_DATA_OUT(ld), .LOAD_LANES_OUT(ll), .CACHEABILITY_ATTRIBUTE_OUT(cca),
    .TLB_VIRTUAL_ADDRESS_OUT(tva), .TLB_FETCH_OR_DATA_SELECT_OUT(tfd), .TLB_LOAD_OR_STORE_SELECT_OUT(tls));
  mem_partner #(.DW(32)) u_mem_partner (.CORE_CLK_IN(clk), .RESET_IN(rst), .bus(link),
    .LAST_COP_WORD_OUT(lw), .COP_FUNC_SEEN_OUT(fs));
  load_store_memory_access_monitor #(.DW(32)) u_monitor (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .req_valid(link.req_valid), .req_write(link.req_write), .req_cached(link.req_cached),
    .req_prefetch(link.req_prefetch), .req_sync(link.req_sync), .req_addr(link.req_addr),
    .req_lanes(link.req_lanes), .rsp_valid(link.rsp_valid), .rsp_lanes_valid(link.rsp_lanes_valid),
    .cop_valid(link.cop_valid), .cop_unit(link.cop_unit), .cop_kind(link.cop_kind), .cop_rvalid(link.cop_rvalid));

  initial begin
    forever #10 clk = ~clk;
  end

  // The bus is watched directly so that forwarded fields are judged where the far end sees them.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (link.req_valid || link.cop_valid) nreq <= nreq + 1;
    if (link.req_valid && link.req_sync) sst <= link.req_stype;
    if (link.cop_valid) sfn <= link.cop_func;
    if (link.cop_valid) sfu <= link.cop_unit;
    if (link.cop_rvalid) cw <= link.cop_rdata[31:0];
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic op(input lsu_op_t c, input logic [31:0] a, input logic [3:0] l, input logic [31:0] d);
    int k;
    opc = c;
    va = a;
    len = l;
    sd = d;
    rv = 1'b1;
    exc = 1'b0;
    @(posedge clk);
    #1;
    rv = 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) begin
      exc = exc | (exo === 1'b1);
      @(posedge clk);
      #1;
    end
    check({done, rdy}, 2'b11);
  endtask : op

  function automatic logic [3:0] lanes(input logic [1:0] f, input logic [3:0] l, input logic b);
    logic [3:0] m;
    m = (4'hf >> (4'h4 - l)) << f;
    lanes = b ? {m[0], m[1], m[2], m[3]} : m;
  endfunction : lanes

  task automatic ldchk(input logic [31:0] a, input logic [3:0] l, input logic [3:0] el, input logic [31:0] ed);
    logic [31:0] m;
    m = {{8{el[3]}}, {8{el[2]}}, {8{el[1]}}, {8{el[0]}}};
    op(OP_LOAD, a, l, 32'h0);
    check(ll, el);
    check(ld & m, ed & m);
  endtask : ldchk

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check({done, rdy}, 2'b01);
    op(OP_STORE, 32'ha000_0010, 4'h4, 32'h11223344);
    op(OP_STORE, 32'ha000_0011, 4'h1, {4{8'h5a}});
    be = 1'b1;
    op(OP_STORE, 32'ha000_0010, 4'h1, {4{8'h7e}});
    be = 1'b0;
    ldchk(32'ha000_0010, 4'h4, 4'hf, 32'h7e225a44);
    check(cca, CCA_UNCACHED);
    for (i = 0; i < 12; i++) begin
      n = (i < 8) ? 4'h1 : 4'h2;
      o = (i < 8) ? i[2:1] : {i[1], 1'b0};
      be = i[0];
      ldchk(32'ha000_0010 + o, n, lanes(o, n, be), 32'h7e225a44);
    end
    be = 1'b0;
    op(OP_LOAD, 32'h8000_0010, 4'h4, 32'h0);
    check(cca, CCA_CACHED);
    check(ld, 32'h7e225a44);
    {th, ta, tp, tc, fd} = {2'b11, 32'h10, 3'h1, 1'b1};
    op(OP_LOAD, 32'h0040_0000, 4'h4, 32'h0);
    check(ld, 32'h7e225a44);
    check(cca, 3'h1);
    check(tva, 32'h0040_0000);
    check({tfd, tls}, 2'b10);
    {th, fd} = 2'b00;
    op(OP_STORE, 32'h0040_0000, 4'h4, 32'hdeadbeef);
    check(exc, 1'b1);
    check({tfd, tls}, 2'b01);
    {th, ta} = 2'b10;
    op(OP_STORE, 32'h0040_0000, 4'h4, 32'hdeadbeef);
    check(exc, 1'b1);
    op(OP_PREFETCH, 32'ha000_0010, 4'h4, 32'h0);
    ldchk(32'ha000_0010, 4'h4, 4'hf, 32'h7e225a44);
    st = 5'h13;
    op(OP_SYNC, 32'h0, 4'h4, 32'h0);
    check(sst, 5'h13);
    {cu, cf} = {2'h2, 25'h1abcde};
    op(OP_COP_FUNCTION, 32'h0, 4'h4, 32'h0);
    check(sfn, 25'h1abcde);
    check({sfu, fs}, 3'b101);
    cu = 2'h1;
    op(OP_COP_LOAD, 32'ha000_0010, 4'h4, 32'h0);
    check(lw, 32'h7e225a44);
    op(OP_STORE, 32'ha000_0018, 4'h4, 32'h0bad_cafe);
    {cdbl, crs} = {1'b1, 5'h7};
    op(OP_COP_LOAD, 32'ha000_0018, 4'h4, 32'h0);
    check(lw, 32'h0bad_cafe);
    {cdbl, crs} = {1'b0, 5'h3};
    op(OP_COP_STORE, 32'ha000_0014, 4'h4, 32'h0);
    check(cw, 32'h7e225a44);
    ldchk(32'ha000_0014, 4'h4, 4'hf, 32'h7e225a44);
    {cdbl, crs} = {1'b1, 5'h7};
    op(OP_COP_STORE, 32'ha000_001c, 4'h4, 32'h0);
    ldchk(32'ha000_001c, 4'h4, 4'hf, 32'h0bad_cafe);
    {cdbl, crs} = {1'b0, 5'h3};
    cu = 2'h0;
    k0 = nreq;
    op(OP_COP_LOAD, 32'ha000_0010, 4'h4, 32'h0);
    check(exc, 1'b1);
    check(nreq - k0, 32'h0);
    summarize();
  end
endmodule : load_store_memory_access_bench
